//--- include/sbs_pkg.sv
// Package of constants and types for the scanner beeper sequencer
package sbs_pkg;

    localparam int unsigned CLK_HZ = 40_000_000;

    // Times as printed
    localparam int unsigned CFG_WINDOW_S = 5;
    localparam int unsigned LEARN_TIMEOUT_S = 35;
    localparam int unsigned PROG_IDLE_S = 10;
    localparam int unsigned LASER_TIMEOUT_MIN = 10;
    localparam int unsigned BEEP_ON_MS = 100;
    localparam int unsigned BEEP_GAP_MS = 100;

    // Tick rate of the millisecond enable
    localparam int unsigned MS_PER_S = 1000;
    localparam int unsigned MS_CYCLES = CLK_HZ / MS_PER_S;

    // Counts in milliseconds
    localparam int unsigned CFG_WINDOW_MS = CFG_WINDOW_S * MS_PER_S;
    localparam int unsigned LEARN_TIMEOUT_MS = LEARN_TIMEOUT_S * MS_PER_S;
    localparam int unsigned PROG_IDLE_MS = PROG_IDLE_S * MS_PER_S;
    localparam int unsigned LASER_TIMEOUT_MS = LASER_TIMEOUT_MIN * 60 * MS_PER_S;

    // Repeat periods of the rate-evaluation pattern
    localparam int unsigned RATE_LOW_MS = MS_PER_S / 1;
    localparam int unsigned RATE_MID_MS = MS_PER_S / 2;
    localparam int unsigned RATE_HIGH_MS = MS_PER_S / 5;

    // Read-rate band limits in percent
    localparam logic [6:0] RATE_LIM_LOW = 7'd30;
    localparam logic [6:0] RATE_LIM_MID = 7'd70;
    localparam logic [6:0] RATE_LIM_HIGH = 7'd90;

    // Volume codes
    localparam logic [1:0] VOL_LOW = 2'h0;
    localparam logic [1:0] VOL_FIXED = 2'h3;

    typedef enum logic [2:0] {
        SBS_MODE_START = 3'b000,
        SBS_MODE_READ = 3'b001,
        SBS_MODE_PERCENT = 3'b010,
        SBS_MODE_RATE = 3'b011,
        SBS_MODE_LEARN = 3'b100,
        SBS_MODE_PROG = 3'b101
    } sbs_mode_t;

    typedef enum logic [1:0] {
        SBS_RES_GOOD = 2'b00,
        SBS_RES_NOREAD = 2'b01,
        SBS_RES_MATCH = 2'b10,
        SBS_RES_OFF = 2'b11
    } sbs_result_fn_t;

endpackage : sbs_pkg

//--- hdl/sbs_beep_player.sv
// Plays a burst of one to three beeps with fixed on and gap times
`timescale 1ns/1ps
`default_nettype none

module sbs_beep_player #(
    parameter int unsigned ON_MS = sbs_pkg::BEEP_ON_MS,
    parameter int unsigned GAP_MS = sbs_pkg::BEEP_GAP_MS
) (
    input wire logic clk_i,          // System clock
    input wire logic reset_n_i,      // Async reset, active low
    input wire logic ms_tick_i,      // Millisecond enable
    input wire logic start_i,        // Start a burst
    input wire logic [1:0] count_i,  // Number of beeps, 1 to 3
    output logic tone_o,             // Tone on
    output logic busy_o              // Burst in progress
);

    localparam int unsigned TW = $clog2(ON_MS + GAP_MS + 1);

    logic [1:0] left;
    logic [TW-1:0] timer;
    logic phase_on;
    logic [1:0] next_left;
    logic [TW-1:0] next_timer;
    logic next_phase_on;

    ////////////////////////////////////////////////////////////////
    always_comb
    begin
        next_left = left;
        next_timer = timer;
        next_phase_on = phase_on;
        if (start_i && count_i != 2'h0)
        begin
            next_left = count_i;
            next_timer = TW'(ON_MS);
            next_phase_on = 1'b1;
        end
        else if (left != 2'h0 && ms_tick_i)
        begin
            if (timer > TW'(1))
            begin
                next_timer = timer - TW'(1);
            end
            else if (phase_on)
            begin
                // Gap after each beep, also after the last one
                next_phase_on = 1'b0;
                next_timer = TW'(GAP_MS);
            end
            else
            begin
                next_left = left - 2'h1;
                next_phase_on = (left != 2'h1);
                next_timer = TW'(ON_MS);
            end
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            left <= 2'h0;
            timer <= '0;
            phase_on <= 1'b0;
        end
        else
        begin
            left <= next_left;
            timer <= next_timer;
            phase_on <= next_phase_on;
        end
    end

    assign tone_o = phase_on && left != 2'h0;
    assign busy_o = left != 2'h0;

endmodule : sbs_beep_player

`default_nettype wire

//--- hdl/sbs_sequencer.sv
// Beeper sequencer: picks tone patterns from operating mode and events
// Summary of operation
// - One beep once the power-up self-test passes.
// - After the 5 s configuration window, double beep entering reading mode.
// - Default result function: one beep per good read.
// - Good-read beep uses the low volume by default.
// - Percentage evaluation mode stays silent.
// - Rate evaluation repeats a double beep at 1 or 2 Hz by band, a single beep at 5 Hz.
// - Rate evaluation above 90 percent gives a continuous tone.
// - Learning mode: one beep for its start or end code.
// - Learning mode: double beep when the application code is read.
// - Learning mode: triple beep if no application code within 35 s.
// - Programming: beep per code, double beep 10 s after the last.
// - Laser timeout in reading mode: laser off, triple beep, pulse stays.
// - Configured volume only in reading mode, otherwise fixed volume.
// - Reading mode follows the configured result function and volume.
// - Both evaluation modes hold switching outputs inactive.
`timescale 1ns/1ps
`default_nettype none

module sbs_sequencer #(
    parameter int unsigned CFG_WINDOW_MS = sbs_pkg::CFG_WINDOW_MS,
    parameter int unsigned LEARN_TIMEOUT_MS = sbs_pkg::LEARN_TIMEOUT_MS,
    parameter int unsigned PROG_IDLE_MS = sbs_pkg::PROG_IDLE_MS,
    parameter int unsigned LASER_TIMEOUT_MS = sbs_pkg::LASER_TIMEOUT_MS,
    parameter int unsigned MS_CYCLES = sbs_pkg::MS_CYCLES,
    parameter int unsigned SW_OUTPUTS = 2
) (
    input wire logic clk_i,                     // System clock, 40 MHz
    input wire logic reset_n_i,                 // Async reset, active low
    input wire logic self_test_ok_i,            // Self-test passed pulse
    input wire logic [2:0] mode_i,              // Requested operating mode
    input wire logic good_read_i,               // Good read with result output
    input wire logic no_read_i,                 // No read at end of pulse
    input wire logic match_i,                   // Match code hit with result
    input wire logic [6:0] read_rate_i,         // Measured read rate, percent
    input wire logic cfg_code_i,                // Configuration code read
    input wire logic learn_edge_code_i,         // Learning start or end code read
    input wire logic app_code_i,                // Application code read
    input wire logic reading_pulse_i,           // Reading pulse active
    input wire logic [1:0] volume_cfg_i,        // Configured volume
    input wire logic [1:0] result_fn_i,         // Configured result function
    input wire logic [SW_OUTPUTS-1:0] sw_req_i, // Switching output requests
    output logic tone_o,                        // Beeper tone on
    output logic [1:0] volume_o,                // Beeper volume
    output logic laser_on_o,                    // Laser diode enable
    output logic reading_mode_o,                // Device in reading mode
    output logic [SW_OUTPUTS-1:0] sw_out_o      // Switching outputs
);

    // Timers must hold the longest timeout and the slowest repeat period
    localparam int unsigned MAX_A = (CFG_WINDOW_MS > LEARN_TIMEOUT_MS) ?
        CFG_WINDOW_MS : LEARN_TIMEOUT_MS;
    localparam int unsigned MAX_B = (PROG_IDLE_MS > LASER_TIMEOUT_MS) ?
        PROG_IDLE_MS : LASER_TIMEOUT_MS;
    localparam int unsigned MAX_C = (MAX_A > MAX_B) ? MAX_A : MAX_B;
    localparam int unsigned MAX_MS = (MAX_C > sbs_pkg::RATE_LOW_MS) ?
        MAX_C : sbs_pkg::RATE_LOW_MS;
    localparam int unsigned CW = $clog2(MAX_MS + 1);
    localparam int unsigned PW = $clog2(MS_CYCLES);

    ////////////////////////////////////////////////////////////////
    // Millisecond enable
    logic [PW-1:0] pre;
    logic ms_tick;
    logic [PW-1:0] next_pre;
    logic next_ms_tick;

    always_comb
    begin
        next_ms_tick = (pre == PW'(MS_CYCLES - 1));
        next_pre = next_ms_tick ? '0 : pre + PW'(1);
    end

    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            pre <= '0;
            ms_tick <= 1'b0;
        end
        else
        begin
            pre <= next_pre;
            ms_tick <= next_ms_tick;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Mode tracking and timers
    sbs_pkg::sbs_mode_t mode;
    sbs_pkg::sbs_mode_t req_mode;
    logic tested;
    logic [CW-1:0] timer;
    logic [CW-1:0] rate_cnt;
    logic laser_off;
    logic prog_seen;
    logic [1:0] beep_req;
    sbs_pkg::sbs_mode_t next_mode;
    logic next_tested;
    logic [CW-1:0] next_timer;
    logic [CW-1:0] next_rate_cnt;
    logic next_laser_off;
    logic next_prog_seen;
    logic [1:0] next_beep_req;
    logic [CW-1:0] rate_period;
    logic [1:0] player_cnt;
    logic player_tone;
    logic player_busy;

    assign req_mode = sbs_pkg::sbs_mode_t'(mode_i);

    always_comb
    begin
        if (read_rate_i < sbs_pkg::RATE_LIM_LOW)
        begin
            rate_period = CW'(sbs_pkg::RATE_LOW_MS);
        end
        else if (read_rate_i <= sbs_pkg::RATE_LIM_MID)
        begin
            rate_period = CW'(sbs_pkg::RATE_MID_MS);
        end
        else
        begin
            rate_period = CW'(sbs_pkg::RATE_HIGH_MS);
        end
    end

    always_comb
    begin
        next_mode = mode;
        next_tested = tested;
        next_timer = timer;
        next_rate_cnt = rate_cnt;
        next_laser_off = laser_off;
        next_prog_seen = prog_seen;
        next_beep_req = 2'h0;
        if (ms_tick)
        begin
            next_timer = timer + CW'(1);
        end
        unique case (mode)
            sbs_pkg::SBS_MODE_START:
            begin
                if (!tested)
                begin
                    next_timer = '0;
                    if (self_test_ok_i)
                    begin
                        next_tested = 1'b1;
                        next_beep_req = 2'h1;
                    end
                end
                else if (cfg_code_i)
                begin
                    next_mode = sbs_pkg::SBS_MODE_PROG;
                    next_timer = '0;
                    next_beep_req = 2'h1;
                end
                else if (timer >= CW'(CFG_WINDOW_MS))
                begin
                    next_mode = sbs_pkg::SBS_MODE_READ;
                    next_timer = '0;
                    next_beep_req = 2'h2;
                end
            end
            sbs_pkg::SBS_MODE_READ:
            begin
                if (!reading_pulse_i)
                begin
                    next_timer = '0;
                    next_laser_off = 1'b0;
                end
                else if (!laser_off && timer >= CW'(LASER_TIMEOUT_MS))
                begin
                    next_laser_off = 1'b1;
                    next_beep_req = 2'h3;
                end
                unique case (sbs_pkg::sbs_result_fn_t'(result_fn_i))
                    sbs_pkg::SBS_RES_GOOD:
                        if (good_read_i) next_beep_req = 2'h1;
                    sbs_pkg::SBS_RES_NOREAD:
                        if (no_read_i) next_beep_req = 2'h1;
                    sbs_pkg::SBS_RES_MATCH:
                        if (match_i) next_beep_req = 2'h1;
                    sbs_pkg::SBS_RES_OFF:
                        next_beep_req = next_beep_req;
                endcase
                if (req_mode != mode && req_mode != sbs_pkg::SBS_MODE_START)
                begin
                    next_mode = req_mode;
                    next_timer = '0;
                    next_rate_cnt = '0;
                    next_laser_off = 1'b0;
                end
            end
            sbs_pkg::SBS_MODE_PERCENT,
            sbs_pkg::SBS_MODE_RATE:
            begin
                if (mode == sbs_pkg::SBS_MODE_RATE && ms_tick)
                begin
                    if (rate_cnt + CW'(1) >= rate_period)
                    begin
                        next_rate_cnt = '0;
                        next_beep_req = 2'h2;
                    end
                    else
                    begin
                        next_rate_cnt = rate_cnt + CW'(1);
                    end
                end
                if (req_mode != mode)
                begin
                    next_mode = (req_mode == sbs_pkg::SBS_MODE_START) ?
                        sbs_pkg::SBS_MODE_READ : req_mode;
                    next_rate_cnt = '0;
                    next_timer = '0;
                end
            end
            sbs_pkg::SBS_MODE_LEARN:
            begin
                if (app_code_i)
                begin
                    next_mode = sbs_pkg::SBS_MODE_READ;
                    next_timer = '0;
                    next_beep_req = 2'h2;
                end
                else if (learn_edge_code_i)
                begin
                    next_beep_req = 2'h1;
                end
                else if (timer >= CW'(LEARN_TIMEOUT_MS))
                begin
                    next_mode = sbs_pkg::SBS_MODE_READ;
                    next_timer = '0;
                    next_beep_req = 2'h3;
                end
            end
            sbs_pkg::SBS_MODE_PROG:
            begin
                if (learn_edge_code_i)
                begin
                    next_mode = sbs_pkg::SBS_MODE_LEARN;
                    next_timer = '0;
                    next_beep_req = 2'h1;
                end
                else if (cfg_code_i)
                begin
                    next_timer = '0;
                    next_prog_seen = 1'b1;
                    next_beep_req = 2'h1;
                end
                else if (timer >= CW'(PROG_IDLE_MS))
                begin
                    next_mode = sbs_pkg::SBS_MODE_READ;
                    next_timer = '0;
                    next_prog_seen = 1'b0;
                    next_beep_req = 2'h2;
                end
            end
            default:
            begin
                next_mode = sbs_pkg::SBS_MODE_READ;
            end
        endcase
    end

    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            mode <= sbs_pkg::SBS_MODE_START;
            tested <= 1'b0;
            timer <= '0;
            rate_cnt <= '0;
            laser_off <= 1'b0;
            prog_seen <= 1'b0;
            beep_req <= 2'h0;
        end
        else
        begin
            mode <= next_mode;
            tested <= next_tested;
            timer <= next_timer;
            rate_cnt <= next_rate_cnt;
            laser_off <= next_laser_off;
            prog_seen <= next_prog_seen;
            beep_req <= next_beep_req;
        end
    end

    assign player_cnt = beep_req;

    sbs_beep_player u_player (
        .clk_i(clk_i),
        .reset_n_i(reset_n_i),
        .ms_tick_i(ms_tick),
        .start_i(beep_req != 2'h0),
        .count_i(player_cnt),
        .tone_o(player_tone),
        .busy_o(player_busy)
    );

    ////////////////////////////////////////////////////////////////
    // Registered outputs
    logic next_tone;
    logic [1:0] next_volume;
    logic next_laser_on;
    logic [SW_OUTPUTS-1:0] next_sw_out;
    logic eval_mode;

    always_comb
    begin
        eval_mode = (mode == sbs_pkg::SBS_MODE_PERCENT) || (mode == sbs_pkg::SBS_MODE_RATE);
        if (mode == sbs_pkg::SBS_MODE_PERCENT)
        begin
            next_tone = 1'b0;
        end
        else if (mode == sbs_pkg::SBS_MODE_RATE && read_rate_i > sbs_pkg::RATE_LIM_HIGH)
        begin
            next_tone = 1'b1;
        end
        else
        begin
            next_tone = player_tone && player_busy;
        end
        next_volume = (mode == sbs_pkg::SBS_MODE_READ) ? volume_cfg_i
            : sbs_pkg::VOL_FIXED;
        next_laser_on = !(mode == sbs_pkg::SBS_MODE_READ && laser_off);
        next_sw_out = eval_mode ? '0 : sw_req_i;
    end

    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            tone_o <= 1'b0;
            volume_o <= sbs_pkg::VOL_FIXED;
            laser_on_o <= 1'b0;
            reading_mode_o <= 1'b0;
            sw_out_o <= '0;
        end
        else
        begin
            tone_o <= next_tone;
            volume_o <= next_volume;
            laser_on_o <= next_laser_on;
            reading_mode_o <= (mode == sbs_pkg::SBS_MODE_READ);
            sw_out_o <= next_sw_out;
        end
    end

endmodule : sbs_sequencer

`default_nettype wire

//--- tb/sbs_sequencer_sva.sv
// Checker of the beeper sequencer port behaviour
`timescale 1ns/1ps
`default_nettype none

module sbs_sequencer_chk #(
    parameter int unsigned MS_CYCLES = 4,
    parameter int unsigned SW_OUTPUTS = 2
) (
    input wire logic clk_i, // Clock
    input wire logic reset_n_i, // Reset
    input wire logic self_test_ok_i, // Self-test
    input wire logic [2:0] mode_i, // Mode
    input wire logic good_read_i, // Good read
    input wire logic no_read_i, // No read
    input wire logic match_i, // Match
    input wire logic [6:0] read_rate_i, // Read rate
    input wire logic cfg_code_i, // Config code
    input wire logic learn_edge_code_i, // Learn code
    input wire logic app_code_i, // App code
    input wire logic reading_pulse_i, // Pulse
    input wire logic [1:0] volume_cfg_i, // Volume set
    input wire logic [1:0] result_fn_i, // Function
    input wire logic [SW_OUTPUTS-1:0] sw_req_i, // Requests
    input wire logic tone_o, // Tone
    input wire logic [1:0] volume_o, // Volume
    input wire logic laser_on_o, // Laser
    input wire logic reading_mode_o, // Reading
    input wire logic [SW_OUTPUTS-1:0] sw_out_o // Outputs
);
    localparam int ON_CYC = sbs_pkg::BEEP_ON_MS * MS_CYCLES;
    // A burst starts between two millisecond ticks, so the first tick comes early
    localparam int ON_MIN = ON_CYC - MS_CYCLES + 1;
    int on_len;
    logic eval_mode;
    assign eval_mode = (mode_i == sbs_pkg::SBS_MODE_PERCENT) || (mode_i == sbs_pkg::SBS_MODE_RATE);

    // Length of the current tone run
    always_ff @(posedge clk_i or negedge reset_n_i)
        if (!reset_n_i)
            on_len <= 0;
        else
            on_len <= tone_o ? on_len + 1 : 0;

    ////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!reset_n_i);

    sequence s_tone_soon;
        ##[0:4] tone_o;
    endsequence
    sequence s_in_eval;
        (eval_mode && !reading_mode_o)[*4];
    endsequence

    a_sw_follow: assert property (reading_mode_o[*3] |-> sw_out_o == $past(sw_req_i))
        else $error("switching outputs not following");
    a_sw_muted: assert property (s_in_eval |-> sw_out_o == '0)
        else $error("switching outputs active in evaluation");
    a_vol_fixed: assert property (!reading_mode_o[*3] |-> volume_o == sbs_pkg::VOL_FIXED)
        else $error("volume not fixed outside reading");
    a_vol_config: assert property (reading_mode_o[*3] ##0 $stable(volume_cfg_i) |-> volume_o == volume_cfg_i)
        else $error("volume not configured value");
    a_percent_quiet: assert property ((mode_i == sbs_pkg::SBS_MODE_PERCENT && !reading_mode_o)[*8] |-> !tone_o)
        else $error("tone in percentage evaluation");
    a_rate_solid: assert property ((mode_i == sbs_pkg::SBS_MODE_RATE && read_rate_i > 7'h5a && !reading_mode_o)[*8] |-> tone_o)
        else $error("no steady tone above top band");
    a_good_beep: assert property (good_read_i && reading_mode_o && result_fn_i == sbs_pkg::SBS_RES_GOOD |-> ##3 tone_o)
        else $error("no beep after good read");
    a_beep_length: assert property ($fell(tone_o) && on_len < 1000 && mode_i != sbs_pkg::SBS_MODE_RATE |-> on_len >= ON_MIN && on_len <= ON_CYC)
        else $error("beep length wrong");
    a_laser_trip: assert property ($fell(laser_on_o) |-> $past(reading_pulse_i) && $past(reading_mode_o))
        else $error("laser off without held pulse");
    a_laser_beep: assert property ($fell(laser_on_o) |-> s_tone_soon)
        else $error("no beep at laser timeout");
endmodule : sbs_sequencer_chk

bind sbs_sequencer sbs_sequencer_chk #(.MS_CYCLES(MS_CYCLES), .SW_OUTPUTS(SW_OUTPUTS)) u_chk (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .self_test_ok_i(self_test_ok_i), .mode_i(mode_i),
    .good_read_i(good_read_i), .no_read_i(no_read_i), .match_i(match_i),
    .read_rate_i(read_rate_i), .cfg_code_i(cfg_code_i), .learn_edge_code_i(learn_edge_code_i),
    .app_code_i(app_code_i), .reading_pulse_i(reading_pulse_i), .volume_cfg_i(volume_cfg_i),
    .result_fn_i(result_fn_i), .sw_req_i(sw_req_i), .tone_o(tone_o), .volume_o(volume_o),
    .laser_on_o(laser_on_o), .reading_mode_o(reading_mode_o), .sw_out_o(sw_out_o)
);

`default_nettype wire

//--- tb/sbs_beeper_model.sv
// Model of the beeper transducer: groups tone pulses into bursts
`timescale 1ns/1ps
`default_nettype none

module sbs_beeper_model #(
    parameter int IDLE = 600
) (
    input wire logic clk_i, // Clock
    input wire logic tone_i, // Tone drive
    output logic burst_o, // Burst ended
    output logic [3:0] beeps_o // Beeps in burst
);
    logic last = 1'b0;
    logic [3:0] cnt = 4'h0;
    int quiet = 0;

    initial
    begin
        burst_o = 1'b0;
        beeps_o = 4'h0;
    end

    // A burst ends once the tone stays quiet longer than any gap
    always @(posedge clk_i)
    begin
        burst_o <= 1'b0;
        quiet <= tone_i ? 0 : quiet + 1;
        if (tone_i && !last)
            cnt <= cnt + 4'h1;
        if (!tone_i && quiet == IDLE && cnt != 4'h0)
        begin
            burst_o <= 1'b1;
            beeps_o <= cnt;
            cnt <= 4'h0;
        end
        last <= tone_i;
    end
endmodule : sbs_beeper_model

`default_nettype wire

//--- tb/test_sbs_sequencer.sv
// Self-checking testbench of the beeper sequencer
`timescale 1ns/1ps
`default_nettype none

module test_sbs_sequencer;
    logic clk_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic [6:0] evt = 7'h00;
    logic [2:0] mode = sbs_pkg::SBS_MODE_READ;
    logic [6:0] rate = 7'h00;
    logic pulse = 1'b0;
    logic [1:0] vol = sbs_pkg::VOL_LOW;
    logic [1:0] fn = sbs_pkg::SBS_RES_GOOD;
    logic [1:0] sw_req = 2'h0;
    logic tone_o, reading_mode_o, laser_on_o, burst;
    logic [1:0] volume_o, sw_out_o;
    logic [3:0] beeps;
    logic watch = 1'b0;
    int errors = 0;
    int samples_checked = 0;
    int cycles = 0;
    int exp_q[$];

    sbs_sequencer #(
        .CFG_WINDOW_MS(500), .LEARN_TIMEOUT_MS(600), .PROG_IDLE_MS(400),
        .LASER_TIMEOUT_MS(10), .MS_CYCLES(4)
    ) u_sbs_sequencer (
        .clk_i(clk_i), .reset_n_i(reset_n_i), .self_test_ok_i(evt[0]), .mode_i(mode),
        .good_read_i(evt[1]), .no_read_i(evt[2]), .match_i(evt[3]), .read_rate_i(rate),
        .cfg_code_i(evt[4]), .learn_edge_code_i(evt[5]), .app_code_i(evt[6]),
        .reading_pulse_i(pulse), .volume_cfg_i(vol), .result_fn_i(fn), .sw_req_i(sw_req),
        .tone_o(tone_o), .volume_o(volume_o), .laser_on_o(laser_on_o),
        .reading_mode_o(reading_mode_o), .sw_out_o(sw_out_o)
    );
    sbs_beeper_model u_sbs_beeper_model (
        .clk_i(clk_i), .tone_i(tone_o), .burst_o(burst), .beeps_o(beeps)
    );

    ////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            errors++;
            $display("unexpected %s: expected %0h, seen %0h", what, exp, seen);
        end
    endtask : check

    task automatic end_sim();
        $display("errors %0d samples_checked %0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : end_sim

    task automatic cyc(input int n);
        repeat (n)
        begin
            @(posedge clk_i);
            #1;
            sw_req = 2'($urandom);
        end
    endtask : cyc

    task automatic rst();
        reset_n_i = 1'b0;
        cyc(6);
        reset_n_i = 1'b1;
        cyc(2);
    endtask : rst

    // Pulse event k (none if negative), note the burst, wait for it
    task automatic beep(input int k, input int n);
        if (n > 0)
            exp_q.push_back(n);
        if (k >= 0)
            evt = 7'h01 << k;
        cyc(1);
        evt = 7'h00;
        for (int i = 0; i < 9000 && exp_q.size() > 0; i++)
            cyc(1);
        check("pending", exp_q.size(), 0);
        cyc(n > 0 ? 20 : 1000);
    endtask : beep

    // Count tone rises in a window that starts at a rise
    task automatic rate_cnt(input logic [6:0] r, input int e);
        int c;
        logic prev;
        c = 0;
        prev = 1'b1;
        rate = r;
        cyc(1000);
        for (int i = 0; i < 5000 && tone_o === 1'b1; i++)
            cyc(1);
        for (int i = 0; i < 5000 && tone_o !== 1'b1; i++)
            cyc(1);
        for (int i = 0; i < 3900; i++)
        begin
            cyc(1);
            if (tone_o && !prev)
                c++;
            prev = tone_o;
        end
        check("rate beeps", c, e);
    endtask : rate_cnt

    ////////////////////////////////////////////////////////////
    initial
    begin
        forever #12.5 clk_i = ~clk_i;
    end

    always @(posedge clk_i)
        if (burst && watch)
            check("beeps", beeps, exp_q.size() > 0 ? exp_q.pop_front() : 0);

    always @(posedge clk_i)
    begin
        cycles++;
        if (cycles == 90000)
        begin
            errors++;
            end_sim();
        end
    end

    initial
    begin
        void'($urandom(28454));
        rst();
        watch = 1'b1;
        check("volume", volume_o, sbs_pkg::VOL_FIXED);
        beep(0, 1);
        check("reading", reading_mode_o, 1'b0);
        beep(-1, 2);
        check("reading", reading_mode_o, 1'b1);
        check("volume", volume_o, sbs_pkg::VOL_LOW);
        vol = 2'($urandom);
        for (int f = 0; f < 4; f++)
        begin
            fn = 2'(f);
            for (int k = 1; k < 4; k++)
                beep(k, (f == k - 1) ? 1 : 0);
        end
        check("volume", volume_o, vol);
        pulse = 1'b1;
        beep(-1, 3);
        check("laser", laser_on_o, 1'b0);
        pulse = 1'b0;
        cyc(4);
        check("laser", laser_on_o, 1'b1);
        mode = sbs_pkg::SBS_MODE_PERCENT;
        beep(1, 0);
        check("switch", sw_out_o, 2'h0);
        watch = 1'b0;
        mode = sbs_pkg::SBS_MODE_RATE;
        rate_cnt(7'h1d, 1);
        rate_cnt(7'h46, 3);
        rate_cnt(7'h5a, 4);
        rate = 7'h5b;
        cyc(1000);
        check("tone", tone_o, 1'b1);
        mode = sbs_pkg::SBS_MODE_READ;
        cyc(2000);
        watch = 1'b1;
        rst();
        beep(0, 1);
        beep(4, 1);
        beep(4, 1);
        check("reading", reading_mode_o, 1'b0);
        beep(-1, 2);
        check("reading", reading_mode_o, 1'b1);
        for (int a = 0; a < 2; a++)
        begin
            rst();
            beep(0, 1);
            beep(4, 1);
            beep(5, 1);
            beep(a ? 6 : -1, a ? 2 : 3);
            check("reading", reading_mode_o, 1'b1);
        end
        end_sim();
    end
endmodule : test_sbs_sequencer

`default_nettype wire
